// ### shared/isau_pkg.sv
// constants and types shared by both ends of the state action unit
package isau_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned CTRL_W = 16;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned ACT_W = 17;
  localparam int unsigned NUM_CNT = 3;

  // action bits of one state; each counter owns a load/count pair
  localparam int unsigned A_ADDR_LOAD = 0;
  localparam int unsigned A_ADDR_COUNT = 1;
  localparam int unsigned A_DATA_LOAD = 2;
  localparam int unsigned A_DATA_COUNT = 3;
  localparam int unsigned A_CTRL_LOAD = 4;
  localparam int unsigned A_CTRL_COUNT = 5;
  localparam int unsigned A_ADDR_CMP = 6;
  localparam int unsigned A_DATA_CMP = 7;
  localparam int unsigned A_CTRL_CMP = 8;
  localparam int unsigned A_CPU_INT = 9;
  localparam int unsigned A_PIN_INT = 10;
  localparam int unsigned A_DRQ = 11;
  localparam int unsigned A_IN_SAMPLE = 12;
  localparam int unsigned A_IN_WRITE = 13;
  localparam int unsigned A_REPEAT = 14;
  localparam int unsigned A_DATA_DRIVE = 15;
  localparam int unsigned A_ADDR_INPUT = 16;

  // counter indices
  localparam int unsigned CNT_ADDR = 0;
  localparam int unsigned CNT_DATA = 1;
  localparam int unsigned CNT_CTRL = 2;

  typedef enum logic [1:0] {
    ISAU_SINK_REG = 2'h0,
    ISAU_SINK_SOCKET = 2'h1,
    ISAU_SINK_PPREG = 2'h2
  } isau_sink_e;

  localparam logic [1:0] THREAD_DEFAULT = 2'h0;

  typedef struct packed {
    logic up;
    logic reload;
    logic [CNT_W-1:0] load;
    logic [CNT_W-1:0] limit;
    logic [CNT_W-1:0] step;
  } isau_cnt_cfg_s;

  // register offsets of the host controller
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_ACTIONS = 12'h004;
  localparam logic [11:0] OFF_ADDR_BUS = 12'h008;
  localparam logic [11:0] OFF_DATA_BUS = 12'h00c;
  localparam logic [11:0] OFF_CTRL_BUS = 12'h010;
  localparam logic [11:0] OFF_CNT_BASE = 12'h014;
  localparam logic [11:0] CNT_STRIDE = 12'h008;
  localparam logic [11:0] CNT_B_OFS = 12'h004;
  localparam logic [11:0] OFF_ADDR_CMP = 12'h02c;
  localparam logic [11:0] OFF_DATA_CMP = 12'h030;
  localparam logic [11:0] OFF_CTRL_CMP = 12'h034;
  localparam logic [11:0] OFF_CMP_MODE = 12'h038;
  localparam logic [11:0] OFF_SINK = 12'h03c;
  localparam logic [11:0] OFF_STATUS = 12'h040;
  localparam logic [11:0] OFF_IN_WORD = 12'h044;
  localparam logic [11:0] OFF_FLAGS = 12'h048;

  // field positions
  localparam int unsigned CTRL_START = 0;
  localparam int unsigned CTRL_ENTER = 1;
  localparam int unsigned CTRL_THREAD_SM = 2;
  localparam int unsigned CTRL_MUXED = 3;
  localparam int unsigned CTRL_DRQ_EN = 4;
  localparam int unsigned CFGB_UP = 16;
  localparam int unsigned CFGB_RELOAD = 17;
  localparam int unsigned SINK_LSB = 0;
  localparam int unsigned THREAD_LSB = 2;
  localparam int unsigned STAT_IRQ = 0;
  localparam int unsigned STAT_DRQ = 1;
  localparam int unsigned STAT_LIM_LSB = 2;
  localparam int unsigned STAT_CMP_LSB = 5;
  localparam int unsigned FLAG_IRQ = 0;
  localparam int unsigned FLAG_DRQ = 1;

  localparam logic [31:0] RST_WORD = 32'h0000_0000;

endpackage : isau_pkg

// ### shared/isau_if.sv
// link between the state action unit and its controller
`timescale 1ns/100ps
`default_nettype none
interface isau_if;
  logic sm_start;
  logic state_enter;
  logic [isau_pkg::ACT_W-1:0] actions;
  logic [isau_pkg::ADDR_W-1:0] addr_bus;
  logic [isau_pkg::DATA_W-1:0] data_bus;
  logic [isau_pkg::CTRL_W-1:0] ctrl_bus;
  isau_pkg::isau_cnt_cfg_s [isau_pkg::NUM_CNT-1:0] cnt_cfg;
  logic [isau_pkg::ADDR_W-1:0] addr_cmp_val;
  logic [isau_pkg::DATA_W-1:0] data_cmp_val;
  logic [isau_pkg::CTRL_W-1:0] ctrl_cmp_val;
  logic [2:0] cmp_change;
  logic [1:0] sink_sel;
  logic [1:0] thread_sel;
  logic thread_by_sm;
  logic port_interrupt_pin;
  logic data_request_pin;
  logic [2:0] limit_hit;
  logic [2:0] cmp_hit;
  logic in_valid;
  logic [isau_pkg::DATA_W-1:0] in_word;

  modport dev (
    input sm_start, state_enter, actions, addr_bus, data_bus, ctrl_bus,
    input cnt_cfg, addr_cmp_val, data_cmp_val, ctrl_cmp_val, cmp_change,
    input sink_sel, thread_sel, thread_by_sm,
    output port_interrupt_pin, data_request_pin, limit_hit, cmp_hit,
    output in_valid, in_word
  );

  modport host (
    output sm_start, state_enter, actions, addr_bus, data_bus, ctrl_bus,
    output cnt_cfg, addr_cmp_val, data_cmp_val, ctrl_cmp_val, cmp_change,
    output sink_sel, thread_sel, thread_by_sm,
    input port_interrupt_pin, data_request_pin, limit_hit, cmp_hit,
    input in_valid, in_word
  );
endinterface : isau_if
`default_nettype wire

// ### hdl/isau_device.sv
// state action unit: counters, compares, events, pins and data input
`timescale 1ns/100ps
`default_nettype none
module isau_device (
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // link to the controller
  isau_if.dev link,
  // internal cpu event
  output logic cpu_event_out,
  // data input sink
  output logic push_valid_out,
  output logic [isau_pkg::DATA_W-1:0] push_word_out,
  output logic [1:0] push_sink_out,
  output logic [1:0] push_thread_out
);

  typedef struct packed {
    logic [isau_pkg::NUM_CNT-1:0][isau_pkg::CNT_W-1:0] cnt;
    logic [isau_pkg::NUM_CNT-1:0] lim_hit;
    logic [2:0] cmp_hit;
    logic [isau_pkg::ADDR_W-1:0] prev_addr;
    logic [isau_pkg::DATA_W-1:0] prev_data;
    logic [isau_pkg::CTRL_W-1:0] prev_ctrl;
    logic prev_ok;
    logic [isau_pkg::DATA_W-1:0] latch;
    logic cpu_evt;
    logic irq_pin;
    logic drq_pin;
    logic push_valid;
    logic [isau_pkg::DATA_W-1:0] push_word;
    logic [1:0] push_sink;
    logic [1:0] push_thread;
  } isau_dev_s;

  isau_dev_s s_r;
  isau_dev_s s_nxt;

  always_comb
  begin
    logic [isau_pkg::CNT_W-1:0] stepped;
    logic ld_act;
    logic cnt_act;
    logic fire;
    logic [isau_pkg::DATA_W-1:0] word;
    stepped = '0;
    ld_act = 1'b0;
    cnt_act = 1'b0;
    fire = 1'b0;
    word = '0;
    s_nxt = s_r;
    s_nxt.cpu_evt = 1'b0;
    s_nxt.push_valid = 1'b0;

    // load bit sits at 2*i, count bit right above it
    for (int i = 0; i < isau_pkg::NUM_CNT; i++)
    begin
      ld_act = link.actions[2*i];
      cnt_act = link.actions[2*i+1];
      if (link.sm_start || (link.state_enter && ld_act))
      begin
        s_nxt.cnt[i] = link.cnt_cfg[i].load;
        s_nxt.lim_hit[i] = 1'b0;
      end
      else if (link.state_enter && cnt_act)
      begin
        if (link.cnt_cfg[i].up)
        begin
          stepped = s_r.cnt[i] + link.cnt_cfg[i].step;
        end
        else
        begin
          stepped = s_r.cnt[i] - link.cnt_cfg[i].step;
        end
        // trigger holds until the next count or load of this counter
        s_nxt.lim_hit[i] = (stepped == link.cnt_cfg[i].limit);
        if (s_nxt.lim_hit[i] && link.cnt_cfg[i].reload)
        begin
          s_nxt.cnt[i] = link.cnt_cfg[i].load;
        end
        else
        begin
          s_nxt.cnt[i] = stepped;
        end
      end
    end

    // compares run every cycle the state holds them
    // change mode needs one earlier sample, so the first cycle never hits
    if (link.cmp_change[0])
    begin
      s_nxt.cmp_hit[0] = link.actions[isau_pkg::A_ADDR_CMP] && s_r.prev_ok &&
                         (link.addr_bus != s_r.prev_addr);
    end
    else
    begin
      s_nxt.cmp_hit[0] = link.actions[isau_pkg::A_ADDR_CMP] &&
                         (link.addr_bus == link.addr_cmp_val);
    end
    if (link.cmp_change[1])
    begin
      s_nxt.cmp_hit[1] = link.actions[isau_pkg::A_DATA_CMP] && s_r.prev_ok &&
                         (link.data_bus != s_r.prev_data);
    end
    else
    begin
      s_nxt.cmp_hit[1] = link.actions[isau_pkg::A_DATA_CMP] &&
                         (link.data_bus == link.data_cmp_val);
    end
    if (link.cmp_change[2])
    begin
      s_nxt.cmp_hit[2] = link.actions[isau_pkg::A_CTRL_CMP] && s_r.prev_ok &&
                         (link.ctrl_bus != s_r.prev_ctrl);
    end
    else
    begin
      s_nxt.cmp_hit[2] = link.actions[isau_pkg::A_CTRL_CMP] &&
                         (link.ctrl_bus == link.ctrl_cmp_val);
    end
    s_nxt.prev_addr = link.addr_bus;
    s_nxt.prev_data = link.data_bus;
    s_nxt.prev_ctrl = link.ctrl_bus;
    s_nxt.prev_ok = 1'b1;

    s_nxt.cpu_evt = link.state_enter &&
                    link.actions[isau_pkg::A_CPU_INT];
    s_nxt.irq_pin = link.actions[isau_pkg::A_PIN_INT];
    s_nxt.drq_pin = link.actions[isau_pkg::A_DRQ];

    // data input acts on entry, or every cycle when the state repeats
    fire = link.state_enter || link.actions[isau_pkg::A_REPEAT];
    if (link.actions[isau_pkg::A_IN_SAMPLE])
    begin
      word = link.data_bus;
    end
    else
    begin
      word = s_r.latch;
    end
    if (fire && link.actions[isau_pkg::A_IN_SAMPLE])
    begin
      s_nxt.latch = link.data_bus;
    end
    if (fire && link.actions[isau_pkg::A_IN_WRITE])
    begin
      s_nxt.push_valid = 1'b1;
      s_nxt.push_word = word;
      s_nxt.push_sink = link.sink_sel;
      if (link.thread_by_sm)
      begin
        s_nxt.push_thread = link.thread_sel;
      end
      else
      begin
        s_nxt.push_thread = isau_pkg::THREAD_DEFAULT;
      end
    end

    if (reset_in)
    begin
      s_nxt = '0;
    end
  end

  always_ff @(posedge clock_in)
  begin
    s_r <= s_nxt;
  end

  assign link.port_interrupt_pin = s_r.irq_pin;
  assign link.data_request_pin = s_r.drq_pin;
  assign link.limit_hit = s_r.lim_hit;
  assign link.cmp_hit = s_r.cmp_hit;
  assign link.in_valid = s_r.push_valid;
  assign link.in_word = s_r.push_word;

  assign cpu_event_out = s_r.cpu_evt;
  assign push_valid_out = s_r.push_valid;
  assign push_word_out = s_r.push_word;
  assign push_sink_out = s_r.push_sink;
  assign push_thread_out = s_r.push_thread;

endmodule : isau_device
`default_nettype wire

// ### hdl/isau_host.sv
// controller end: apb registers that steer the action unit link
`timescale 1ns/100ps
`default_nettype none
module isau_host (
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // link to the action unit
  isau_if.host link
);

  typedef struct packed {
    logic start;
    logic enter;
    logic thread_sm;
    logic muxed;
    logic drq_en;
    logic [isau_pkg::ACT_W-1:0] act;
    logic [isau_pkg::ADDR_W-1:0] addr_bus;
    logic [isau_pkg::DATA_W-1:0] data_bus;
    logic [isau_pkg::CTRL_W-1:0] ctrl_bus;
    logic [isau_pkg::NUM_CNT-1:0][31:0] cfga;
    logic [isau_pkg::NUM_CNT-1:0][31:0] cfgb;
    logic [isau_pkg::ADDR_W-1:0] addr_cmp;
    logic [isau_pkg::DATA_W-1:0] data_cmp;
    logic [isau_pkg::CTRL_W-1:0] ctrl_cmp;
    logic [2:0] cmp_mode;
    logic [1:0] sink;
    logic [1:0] thread;
    logic irq_seen;
    logic drq_seen;
    logic [31:0] last_word;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } isau_host_s;

  isau_host_s s_r;
  isau_host_s s_nxt;

  always_comb
  begin
    logic acc;
    logic take;
    logic hit;
    logic bad;
    logic [31:0] rd;
    logic [isau_pkg::ACT_W-1:0] a;
    acc = psel_in && penable_in;
    take = acc && s_r.pready;
    hit = 1'b1;
    bad = 1'b0;
    rd = isau_pkg::RST_WORD;
    a = pwdata_in[isau_pkg::ACT_W-1:0];
    s_nxt = s_r;
    s_nxt.start = 1'b0;
    s_nxt.enter = 1'b0;

    // an action word with forbidden pairings is refused whole
    bad = (a[isau_pkg::A_ADDR_LOAD] && a[isau_pkg::A_ADDR_COUNT]) ||
          (a[isau_pkg::A_DATA_LOAD] && a[isau_pkg::A_DATA_COUNT]) ||
          (a[isau_pkg::A_CTRL_LOAD] && a[isau_pkg::A_CTRL_COUNT]);
    bad = bad || (s_r.muxed && a[isau_pkg::A_ADDR_CMP] &&
          (a[isau_pkg::A_IN_SAMPLE] || a[isau_pkg::A_IN_WRITE]));
    bad = bad || (a[isau_pkg::A_DATA_CMP] && a[isau_pkg::A_DATA_DRIVE]) ||
          (s_r.muxed && a[isau_pkg::A_DATA_CMP] &&
          a[isau_pkg::A_ADDR_INPUT]);

    case (paddr_in)
      isau_pkg::OFF_CTRL: rd = {27'h0, s_r.drq_en, s_r.muxed, s_r.thread_sm,
                                2'h0};
      isau_pkg::OFF_ACTIONS: rd = {15'h0, s_r.act};
      isau_pkg::OFF_ADDR_BUS: rd = {24'h0, s_r.addr_bus};
      isau_pkg::OFF_DATA_BUS: rd = s_r.data_bus;
      isau_pkg::OFF_CTRL_BUS: rd = {16'h0, s_r.ctrl_bus};
      isau_pkg::OFF_ADDR_CMP: rd = {24'h0, s_r.addr_cmp};
      isau_pkg::OFF_DATA_CMP: rd = s_r.data_cmp;
      isau_pkg::OFF_CTRL_CMP: rd = {16'h0, s_r.ctrl_cmp};
      isau_pkg::OFF_CMP_MODE: rd = {29'h0, s_r.cmp_mode};
      isau_pkg::OFF_SINK: rd = {28'h0, s_r.thread, s_r.sink};
      isau_pkg::OFF_STATUS: rd = {24'h0, link.cmp_hit, link.limit_hit,
                                  link.data_request_pin,
                                  link.port_interrupt_pin};
      isau_pkg::OFF_IN_WORD: rd = s_r.last_word;
      isau_pkg::OFF_FLAGS: rd = {30'h0, s_r.drq_seen, s_r.irq_seen};
      default: hit = 1'b0;
    endcase
    for (int i = 0; i < isau_pkg::NUM_CNT; i++)
    begin
      if (paddr_in == 12'(isau_pkg::OFF_CNT_BASE + isau_pkg::CNT_STRIDE * i))
      begin
        hit = 1'b1;
        rd = s_r.cfga[i];
      end
      if (paddr_in == 12'(isau_pkg::OFF_CNT_BASE + isau_pkg::CNT_STRIDE * i +
                          isau_pkg::CNT_B_OFS))
      begin
        hit = 1'b1;
        rd = s_r.cfgb[i];
      end
    end

    // one wait cycle in the access phase; answer is computed meanwhile
    s_nxt.pready = acc && !s_r.pready;
    if (acc && !s_r.pready)
    begin
      s_nxt.prdata = pwrite_in ? isau_pkg::RST_WORD : rd;
      s_nxt.pslverr = !hit || (pwrite_in &&
                      paddr_in == isau_pkg::OFF_ACTIONS && bad);
    end

    if (take && pwrite_in && !s_r.pslverr)
    begin
      case (paddr_in)
        isau_pkg::OFF_CTRL:
        begin
          s_nxt.start = pwdata_in[isau_pkg::CTRL_START];
          s_nxt.enter = pwdata_in[isau_pkg::CTRL_ENTER];
          s_nxt.thread_sm = pwdata_in[isau_pkg::CTRL_THREAD_SM];
          s_nxt.muxed = pwdata_in[isau_pkg::CTRL_MUXED];
          s_nxt.drq_en = pwdata_in[isau_pkg::CTRL_DRQ_EN];
        end
        isau_pkg::OFF_ACTIONS: s_nxt.act = a;
        isau_pkg::OFF_ADDR_BUS: s_nxt.addr_bus = pwdata_in[7:0];
        isau_pkg::OFF_DATA_BUS: s_nxt.data_bus = pwdata_in;
        isau_pkg::OFF_CTRL_BUS: s_nxt.ctrl_bus = pwdata_in[15:0];
        isau_pkg::OFF_ADDR_CMP: s_nxt.addr_cmp = pwdata_in[7:0];
        isau_pkg::OFF_DATA_CMP: s_nxt.data_cmp = pwdata_in;
        isau_pkg::OFF_CTRL_CMP: s_nxt.ctrl_cmp = pwdata_in[15:0];
        isau_pkg::OFF_CMP_MODE: s_nxt.cmp_mode = pwdata_in[2:0];
        isau_pkg::OFF_SINK:
        begin
          s_nxt.sink = pwdata_in[isau_pkg::SINK_LSB +: 2];
          s_nxt.thread = pwdata_in[isau_pkg::THREAD_LSB +: 2];
        end
        isau_pkg::OFF_FLAGS:
        begin
          s_nxt.irq_seen = s_r.irq_seen && !pwdata_in[isau_pkg::FLAG_IRQ];
          s_nxt.drq_seen = s_r.drq_seen && !pwdata_in[isau_pkg::FLAG_DRQ];
        end
        default:
        begin
          for (int i = 0; i < isau_pkg::NUM_CNT; i++)
          begin
            if (paddr_in ==
                12'(isau_pkg::OFF_CNT_BASE + isau_pkg::CNT_STRIDE * i))
            begin
              s_nxt.cfga[i] = pwdata_in;
            end
            if (paddr_in == 12'(isau_pkg::OFF_CNT_BASE +
                isau_pkg::CNT_STRIDE * i + isau_pkg::CNT_B_OFS))
            begin
              s_nxt.cfgb[i] = pwdata_in;
            end
          end
        end
      endcase
    end

    // pins set sticky flags after the clear so a same-cycle event wins
    if (link.port_interrupt_pin)
    begin
      s_nxt.irq_seen = 1'b1;
    end
    if (link.data_request_pin && s_r.drq_en)
    begin
      s_nxt.drq_seen = 1'b1;
    end
    if (link.in_valid)
    begin
      s_nxt.last_word = link.in_word;
    end

    if (reset_in)
    begin
      s_nxt = '0;
    end
  end

  always_ff @(posedge clock_in)
  begin
    s_r <= s_nxt;
  end

  assign prdata_out = s_r.prdata;
  assign pready_out = s_r.pready;
  assign pslverr_out = s_r.pslverr;

  assign link.sm_start = s_r.start;
  assign link.state_enter = s_r.enter;
  assign link.actions = s_r.act;
  assign link.addr_bus = s_r.addr_bus;
  assign link.data_bus = s_r.data_bus;
  assign link.ctrl_bus = s_r.ctrl_bus;
  assign link.addr_cmp_val = s_r.addr_cmp;
  assign link.data_cmp_val = s_r.data_cmp;
  assign link.ctrl_cmp_val = s_r.ctrl_cmp;
  assign link.cmp_change = s_r.cmp_mode;
  assign link.sink_sel = s_r.sink;
  assign link.thread_sel = s_r.thread;
  assign link.thread_by_sm = s_r.thread_sm;

  for (genvar g = 0; g < isau_pkg::NUM_CNT; g++)
  begin : g_cfg
    assign link.cnt_cfg[g].up = s_r.cfgb[g][isau_pkg::CFGB_UP];
    assign link.cnt_cfg[g].reload = s_r.cfgb[g][isau_pkg::CFGB_RELOAD];
    assign link.cnt_cfg[g].load = s_r.cfga[g][15:0];
    assign link.cnt_cfg[g].limit = s_r.cfga[g][31:16];
    assign link.cnt_cfg[g].step = s_r.cfgb[g][15:0];
  end

endmodule : isau_host
`default_nettype wire

// ### verification/isau_props.sv
// concurrent checks on the link between host and action unit
`timescale 1ns/100ps
`default_nettype none
module isau_props (
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // host to unit
  input wire logic sm_start,
  input wire logic state_enter,
  input wire logic [16:0] actions,
  input wire logic [7:0] addr_bus,
  input wire logic [31:0] data_bus,
  input wire logic [15:0] ctrl_bus,
  input wire logic [7:0] addr_cmp_val,
  input wire logic [31:0] data_cmp_val,
  input wire logic [15:0] ctrl_cmp_val,
  input wire logic [2:0] cmp_change,
  // unit to host
  input wire logic port_interrupt_pin,
  input wire logic data_request_pin,
  input wire logic [2:0] limit_hit,
  input wire logic [2:0] cmp_hit,
  input wire logic in_valid,
  input wire logic [31:0] in_word
);
  default clocking @(posedge clock_in);
  endclocking
  default disable iff (reset_in);

  pin_irq_a: assert property (
    port_interrupt_pin == $past(actions[isau_pkg::A_PIN_INT]))
    else $error("interrupt pin not following its action");
  pin_drq_a: assert property (
    data_request_pin == $past(actions[isau_pkg::A_DRQ]))
    else $error("request pin not following its action");
  in_push_a: assert property (
    state_enter && actions[isau_pkg::A_IN_SAMPLE]
    && actions[isau_pkg::A_IN_WRITE]
    |=> in_valid && in_word == $past(data_bus))
    else $error("sampled word not pushed");
  no_write_a: assert property (
    !actions[isau_pkg::A_IN_WRITE] |=> !in_valid)
    else $error("push without write option");
  idle_push_a: assert property (
    !state_enter && !actions[isau_pkg::A_REPEAT] |=> !in_valid)
    else $error("push outside state entry");
  addr_cmp_a: assert property (
    actions[isau_pkg::A_ADDR_CMP] && !cmp_change[0]
    |=> cmp_hit[0] == ($past(addr_bus) == $past(addr_cmp_val)))
    else $error("address compare wrong");
  data_cmp_a: assert property (
    actions[isau_pkg::A_DATA_CMP] && !cmp_change[1]
    |=> cmp_hit[1] == ($past(data_bus) == $past(data_cmp_val)))
    else $error("data compare wrong");
  ctrl_cmp_a: assert property (
    actions[isau_pkg::A_CTRL_CMP] && !cmp_change[2]
    |=> cmp_hit[2] == ($past(ctrl_bus) == $past(ctrl_cmp_val)))
    else $error("control compare wrong");
  addr_chg_a: assert property (
    actions[isau_pkg::A_ADDR_CMP] && cmp_change[0]
    && addr_bus != $past(addr_bus) |=> cmp_hit[0])
    else $error("address change not flagged");
  lim_hold_a: assert property (
    !state_enter && !sm_start |=> $stable(limit_hit))
    else $error("limit trigger moved without cause");
endmodule : isau_props
`default_nettype wire

// ### verification/tb_top.sv
// self-checking bench for the joined host and action unit
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clock_in = 1'b0;
  logic reset_in = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h0;
  logic [31:0] seed = 32'h3d29c159;
  logic [31:0] prd, rd, ctl, d, e, pw;
  logic [15:0] ld, st;
  logic prdy, perr, re, ev, pv, up;
  logic [1:0] ps, pt, th;
  logic [31:0] bad [6] = '{32'h3, 32'hc, 32'h30, 32'h3040, 32'h8080,
    32'h10080};
  int failures = 0, total_checks = 0, cyc = 0, evs = 0, pushes = 0;
  int i, k, n;
  isau_if link ();
  isau_host i_isau_host (.clock_in(clock_in), .reset_in(reset_in),
    .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa),
    .pwdata_in(pwd), .prdata_out(prd), .pready_out(prdy),
    .pslverr_out(perr), .link(link));
  isau_device i_isau_device (.clock_in(clock_in), .reset_in(reset_in),
    .link(link), .cpu_event_out(ev), .push_valid_out(pv),
    .push_word_out(pw), .push_sink_out(ps), .push_thread_out(pt));
  isau_props i_isau_props (.clock_in(clock_in), .reset_in(reset_in),
    .sm_start(link.sm_start), .state_enter(link.state_enter),
    .actions(link.actions), .addr_bus(link.addr_bus),
    .data_bus(link.data_bus), .ctrl_bus(link.ctrl_bus),
    .addr_cmp_val(link.addr_cmp_val), .data_cmp_val(link.data_cmp_val),
    .ctrl_cmp_val(link.ctrl_cmp_val), .cmp_change(link.cmp_change),
    .port_interrupt_pin(link.port_interrupt_pin),
    .data_request_pin(link.data_request_pin), .limit_hit(link.limit_hit),
    .cmp_hit(link.cmp_hit), .in_valid(link.in_valid),
    .in_word(link.in_word));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  // counters wrap at 16 bits, so the expectation wraps too
  function automatic logic [15:0] nv(input logic [15:0] l,
    input logic [15:0] s, input logic u, input int c);
    return u ? l + 16'(c) * s : l - 16'(c) * s;
  endfunction : nv

  task automatic finish_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    total_checks++;
    if (s !== x)
    begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, x);
    end
  endtask : chk

  // one idle cycle after each transfer keeps psel from two drives per step
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] v);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    pa <= a;
    pwd <= v;
    @(posedge clock_in);
    pen <= 1'b1;
    do
      @(posedge clock_in);
    while (prdy !== 1'b1);
    rd = prd;
    re = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clock_in);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    apb(1'b1, a, v);
  endtask : wr

  // pulse state entry, then let the unit's outputs land
  task automatic enter();
    wr(isau_pkg::OFF_CTRL, ctl | 32'h2);
    repeat (2) @(posedge clock_in);
  endtask : enter

  initial
  begin
    forever #20 clock_in = ~clock_in;
  end

  always @(posedge clock_in)
  begin
    cyc++;
    if (ev === 1'b1)
      evs++;
    if (pv === 1'b1)
      pushes++;
    if (cyc == 8000)
    begin
      failures++;
      finish_test();
    end
  end

  initial
  begin
    repeat (2) @(posedge clock_in);
    reset_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    apb(1'b0, isau_pkg::OFF_STATUS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h0fc, 32'h0);
    chk({31'h0, re}, 32'h1);
    ctl = 32'h8;
    wr(isau_pkg::OFF_CTRL, ctl);
    wr(isau_pkg::OFF_ACTIONS, 32'h400);
    for (i = 0; i < 6; i++)
    begin
      wr(isau_pkg::OFF_ACTIONS, bad[i]);
      chk({31'h0, re}, 32'h1);
    end
    apb(1'b0, isau_pkg::OFF_ACTIONS, 32'h0);
    chk(rd, 32'h400);
    wr(isau_pkg::OFF_ACTIONS, 32'hc00);
    apb(1'b0, isau_pkg::OFF_STATUS, 32'h0);
    chk({30'h0, rd[1:0]}, 32'h3);
    wr(isau_pkg::OFF_ACTIONS, 32'h200);
    enter();
    chk(32'(evs), 32'h1);
    for (i = 0; i < 3; i++)
    begin
      ld = 16'(xs());
      st = {8'h0, 8'(xs())} | 16'h1;
      up = 1'(xs());
      wr(isau_pkg::OFF_CNT_BASE + 12'(8 * i), {nv(ld, st, up, 3), ld});
      wr(isau_pkg::OFF_CNT_BASE + 12'(8 * i + 4), {15'h1, up, st});
      wr(isau_pkg::OFF_ACTIONS, 32'h2 << (2 * i));
      wr(isau_pkg::OFF_CTRL, ctl | 32'h1);
      for (k = 1; k <= 7; k++)
      begin
        enter();
        apb(1'b0, isau_pkg::OFF_STATUS, 32'h0);
        chk({29'h0, rd[4:2]}, (k % 3 == 0) ? 32'h1 << i : 32'h0);
      end
    end
    ctl = 32'h4;
    wr(isau_pkg::OFF_CTRL, ctl);
    for (i = 0; i < 3; i++)
    begin
      th = 2'(xs());
      d = xs();
      e = xs();
      wr(isau_pkg::OFF_SINK, {28'h0, th, 2'(i)});
      wr(isau_pkg::OFF_DATA_BUS, d);
      wr(isau_pkg::OFF_ACTIONS, 32'h3000);
      enter();
      chk(pw, d);
      chk({28'h0, pt, ps}, {28'h0, th, 2'(i)});
      wr(isau_pkg::OFF_DATA_BUS, e);
      wr(isau_pkg::OFF_ACTIONS, 32'h1000);
      n = pushes;
      enter();
      chk(32'(pushes), 32'(n));
      wr(isau_pkg::OFF_DATA_BUS, xs());
      wr(isau_pkg::OFF_ACTIONS, 32'h2000);
      enter();
      chk(pw, e);
    end
    chk(32'(pushes), 32'h6);
    apb(1'b0, isau_pkg::OFF_IN_WORD, 32'h0);
    chk(rd, e);
    // drq handling is still off, so only the interrupt flag was caught
    apb(1'b0, isau_pkg::OFF_FLAGS, 32'h0);
    chk(rd, 32'h1);
    wr(isau_pkg::OFF_FLAGS, 32'h3);
    apb(1'b0, isau_pkg::OFF_FLAGS, 32'h0);
    chk(rd, 32'h0);
    wr(isau_pkg::OFF_CTRL, 32'h10);
    wr(isau_pkg::OFF_ACTIONS, 32'h800);
    apb(1'b0, isau_pkg::OFF_FLAGS, 32'h0);
    chk(rd, 32'h2);
    // a nonzero thread left behind must not leak through
    wr(isau_pkg::OFF_SINK, 32'hc);
    ctl = 32'h0;
    wr(isau_pkg::OFF_ACTIONS, 32'h3000);
    enter();
    chk({28'h0, pt, ps}, 32'h0);
    d = xs();
    wr(isau_pkg::OFF_ADDR_BUS, d);
    wr(isau_pkg::OFF_ADDR_CMP, d);
    wr(isau_pkg::OFF_DATA_BUS, d);
    wr(isau_pkg::OFF_DATA_CMP, ~d);
    wr(isau_pkg::OFF_CTRL_BUS, d);
    wr(isau_pkg::OFF_CTRL_CMP, d);
    wr(isau_pkg::OFF_ACTIONS, 32'h1c0);
    apb(1'b0, isau_pkg::OFF_STATUS, 32'h0);
    chk({29'h0, rd[7:5]}, 32'h5);
    wr(isau_pkg::OFF_CMP_MODE, 32'h7);
    apb(1'b0, isau_pkg::OFF_STATUS, 32'h0);
    chk({29'h0, rd[7:5]}, 32'h0);
    // change hit lasts one cycle; the checker sees it, status sees it gone
    wr(isau_pkg::OFF_ADDR_BUS, ~d);
    apb(1'b0, isau_pkg::OFF_STATUS, 32'h0);
    chk({29'h0, rd[7:5]}, 32'h0);
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
